// [logic/mhp_host_port.sv]
// Host bus front end: 6800, 8080, 4-wire SPI and I2C receivers
`timescale 1ns/1ps
module mhp_host_port (
  input  wire logic       i_ref_clk,
  input  wire logic       i_resetn,
  input  wire logic       i_protocol_strap_a,
  input  wire logic       i_protocol_strap_b,
  input  wire logic       i_cs_n,
  input  wire logic       i_power_reset_in_n,
  input  wire logic       i_data_command_select,
  input  wire logic       i_write_strobe_or_dir,
  input  wire logic       i_read_strobe_or_enable,
  input  wire logic [7:0] i_bus,
  output logic      [7:0] o_bus,
  output logic      [7:0] o_bus_oe_n,
  input  wire logic [7:0] i_rd_data,
  output logic            o_rd_taken,
  output logic            o_rx_valid,
  output logic      [7:0] o_rx_byte,
  output logic            o_rx_is_data,
  output logic      [1:0] o_mode,
  output logic            o_ctrl_reset
);
  // ****************************************
  // Pin synchronisation and edge detection
  // ****************************************
  logic [13:0] pins_raw;
  logic [13:0] pins;
  logic [13:0] pins_d;
  logic        rst_sync;

  assign pins_raw = {i_read_strobe_or_enable, i_write_strobe_or_dir, i_data_command_select,
                     i_cs_n, i_protocol_strap_b, i_protocol_strap_a, i_bus};

  mhp_sync #(.W(14), .RV(mhp_pkg::PIN_RESET)) u_pin_sync (
    .i_ref_clk (i_ref_clk),
    .i_resetn  (i_resetn),
    .i_async   (pins_raw),
    .o_sync    (pins)
  );

  mhp_sync #(.W(1), .RV(1'b1)) u_rst_sync (
    .i_ref_clk (i_ref_clk),
    .i_resetn  (i_resetn),
    .i_async   (i_power_reset_in_n),
    .o_sync    (rst_sync)
  );

  // Previous synchronised levels for edge finding
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      pins_d <= mhp_pkg::PIN_RESET;
    end else begin
      pins_d <= pins;
    end
  end

  function automatic logic rose(input logic now, input logic was);
    rose = now & ~was;
  endfunction

  logic [7:0] bus;
  logic       cs_act;
  logic       dc;
  logic       wr;
  logic       rde;
  logic       scl;
  logic       sda;
  logic       scl_rise;
  logic       scl_fall;
  logic       wr_rise;
  logic       rde_fall;
  logic       busy_reset;

  assign bus        = pins[7:0];
  assign cs_act     = ~pins[mhp_pkg::PIN_CS_N];
  assign dc         = pins[mhp_pkg::PIN_DC];
  assign wr         = pins[mhp_pkg::PIN_WR];
  assign rde        = pins[mhp_pkg::PIN_RDE];
  assign scl        = pins[mhp_pkg::SER_CLK_BIT];
  assign sda        = pins[mhp_pkg::SER_DAT_BIT];
  assign scl_rise   = rose(scl, pins_d[mhp_pkg::SER_CLK_BIT]);
  assign scl_fall   = rose(pins_d[mhp_pkg::SER_CLK_BIT], scl);
  assign wr_rise    = rose(wr, pins_d[mhp_pkg::PIN_WR]);
  assign rde_fall   = rose(pins_d[mhp_pkg::PIN_RDE], rde);
  assign busy_reset = ~rst_sync;

  // ****************************************
  // Mode decode and controller reset
  // ****************************************
  mhp_pkg::mhp_mode_t mode;

  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      mode         <= mhp_pkg::MHP_SPI;
      o_mode       <= 2'h0;
      o_ctrl_reset <= 1'b1;
    end else begin
      mode         <= mhp_pkg::mhp_mode_t'({pins[mhp_pkg::PIN_STRAP_B], pins[mhp_pkg::PIN_STRAP_A]});
      o_mode       <= mode;
      o_ctrl_reset <= busy_reset;
    end
  end

  // ****************************************
  // Serial shift state (SPI and I2C)
  // ****************************************
  typedef enum logic [1:0] {
    I2C_IDLE = 2'b00,
    I2C_ADDR = 2'b01,
    I2C_CTRL = 2'b10,
    I2C_BYTE = 2'b11
  } mhp_i2c_t;

  mhp_i2c_t   i2c_st;
  logic [7:0] shift;
  logic [3:0] bit_cnt;
  logic       i2c_ack;
  logic       i2c_co;
  logic       i2c_dc;
  logic       i2c_start;
  logic       i2c_stop;
  logic       byte_done;

  assign i2c_start = scl & pins_d[mhp_pkg::SER_CLK_BIT] & pins_d[mhp_pkg::SER_DAT_BIT] & ~sda;
  assign i2c_stop  = scl & pins_d[mhp_pkg::SER_CLK_BIT] & ~pins_d[mhp_pkg::SER_DAT_BIT] & sda;
  assign byte_done = (bit_cnt == mhp_pkg::BITS_PER_BYTE);

  // Bit counter and shifter, MSB first on clock rise
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      shift   <= mhp_pkg::BYTE_RESET;
      bit_cnt <= 4'h0;
    end else if (busy_reset || !cs_act || (mode == mhp_pkg::MHP_I2C && (i2c_start || i2c_stop))) begin
      bit_cnt <= 4'h0;
    end else if (mode == mhp_pkg::MHP_SPI && scl_rise) begin
      shift   <= {shift[6:0], sda};
      bit_cnt <= byte_done ? 4'h1 : bit_cnt + 4'h1;
    end else if (mode == mhp_pkg::MHP_I2C && scl_rise && !byte_done && i2c_st != I2C_IDLE) begin
      shift   <= {shift[6:0], sda};
      bit_cnt <= bit_cnt + 4'h1;
    end else if (mode == mhp_pkg::MHP_I2C && scl_fall && i2c_ack) begin
      bit_cnt <= 4'h0;
    end
  end

  // I2C framing: address, control byte, payload, acknowledge
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      i2c_st  <= I2C_IDLE;
      i2c_ack <= 1'b0;
      i2c_co  <= 1'b0;
      i2c_dc  <= 1'b0;
    end else if (busy_reset || !cs_act || mode != mhp_pkg::MHP_I2C || i2c_stop) begin
      i2c_st  <= I2C_IDLE;
      i2c_ack <= 1'b0;
    end else if (i2c_start) begin
      i2c_st  <= I2C_ADDR;
      i2c_ack <= 1'b0;
    end else if (scl_fall && i2c_ack) begin
      i2c_ack <= 1'b0; // Release SDA after the ninth clock
    end else if (scl_fall && byte_done) begin
      case (i2c_st)
        I2C_ADDR: begin
          i2c_ack <= (shift[7:1] == mhp_pkg::I2C_ADDR) && !shift[0];
          i2c_st  <= ((shift[7:1] == mhp_pkg::I2C_ADDR) && !shift[0]) ? I2C_CTRL : I2C_IDLE;
        end
        I2C_CTRL: begin
          i2c_ack <= 1'b1;
          i2c_co  <= shift[mhp_pkg::I2C_CO_BIT];
          i2c_dc  <= shift[mhp_pkg::I2C_DC_BIT];
          i2c_st  <= I2C_BYTE;
        end
        I2C_BYTE: begin
          i2c_ack <= 1'b1;
          i2c_st  <= i2c_co ? I2C_CTRL : I2C_BYTE;
        end
        default: begin
          i2c_st  <= I2C_IDLE;
        end
      endcase
    end
  end

  // ****************************************
  // Received byte output
  // ****************************************
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_rx_valid   <= 1'b0;
      o_rx_byte    <= mhp_pkg::BYTE_RESET;
      o_rx_is_data <= 1'b0;
    end else begin
      o_rx_valid <= 1'b0;
      if (!busy_reset && cs_act) begin
        case (mode)
          mhp_pkg::MHP_I8080: begin
            if (wr_rise) begin
              o_rx_valid   <= 1'b1;
              o_rx_byte    <= bus;
              o_rx_is_data <= dc;
            end
          end
          mhp_pkg::MHP_M6800: begin
            if (rde_fall && !wr) begin
              o_rx_valid   <= 1'b1;
              o_rx_byte    <= bus;
              o_rx_is_data <= dc;
            end
          end
          mhp_pkg::MHP_SPI: begin
            if (byte_done && pins_d[mhp_pkg::SER_CLK_BIT] && scl_fall) begin
              o_rx_valid   <= 1'b1;
              o_rx_byte    <= shift;
              o_rx_is_data <= dc;
            end
          end
          mhp_pkg::MHP_I2C: begin
            if (scl_fall && byte_done && !i2c_ack && i2c_st == I2C_BYTE) begin
              o_rx_valid   <= 1'b1;
              o_rx_byte    <= shift;
              o_rx_is_data <= i2c_dc;
            end
          end
          default: begin
            o_rx_valid <= 1'b0;
          end
        endcase
      end
    end
  end

  // ****************************************
  // Bus drivers for reads and I2C acknowledge
  // ****************************************
  logic par_read;
  logic par_read_d;

  assign par_read = !busy_reset && cs_act &&
                    ((mode == mhp_pkg::MHP_I8080 && !rde) ||
                     (mode == mhp_pkg::MHP_M6800 && rde && wr));

  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      par_read_d <= 1'b0;
      o_rd_taken <= 1'b0;
      o_bus      <= 8'h00;
      o_bus_oe_n <= 8'hff;
    end else begin
      par_read_d <= par_read;
      o_rd_taken <= par_read_d & ~par_read; // Read cycle closed
      if (par_read) begin
        o_bus      <= i_rd_data;
        o_bus_oe_n <= 8'h00;
      end else if (mode == mhp_pkg::MHP_I2C && i2c_ack && cs_act) begin
        o_bus      <= 8'h00;
        o_bus_oe_n <= 8'hfd;
      end else begin
        o_bus      <= 8'h00;
        o_bus_oe_n <= 8'hff;
      end
    end
  end
endmodule

// [logic/mhp_pkg.sv]
// Constants shared by the multi-protocol host port
package mhp_pkg;
  // ****************************************
  // Protocol selection
  // ****************************************
  typedef enum logic [1:0] {
    MHP_SPI    = 2'b00,
    MHP_I2C    = 2'b01,
    MHP_M6800  = 2'b10,
    MHP_I8080  = 2'b11
  } mhp_mode_t;

  // ****************************************
  // Pin vector layout
  // ****************************************
  localparam int unsigned     BUS_W        = 8;
  localparam int unsigned     SER_CLK_BIT  = 0;
  localparam int unsigned     SER_DAT_BIT  = 1;
  localparam int unsigned     PIN_W        = 14;
  localparam int unsigned     PIN_BUS_LSB  = 0;
  localparam int unsigned     PIN_STRAP_A  = 8;
  localparam int unsigned     PIN_STRAP_B  = 9;
  localparam int unsigned     PIN_CS_N     = 10;
  localparam int unsigned     PIN_DC       = 11;
  localparam int unsigned     PIN_WR       = 12;
  localparam int unsigned     PIN_RDE      = 13;
  localparam logic [13:0]     PIN_RESET    = 14'h3c00;

  // ****************************************
  // Serial framing
  // ****************************************
  localparam logic [3:0]      BITS_PER_BYTE = 4'h8;
  localparam logic [6:0]      I2C_ADDR      = 7'h3c;
  localparam int unsigned     I2C_CO_BIT    = 7;
  localparam int unsigned     I2C_DC_BIT    = 6;
  localparam logic [7:0]      BYTE_RESET    = 8'h00;
endpackage

// [logic/mhp_sync.sv]
// Two-stage synchroniser for a vector of pin levels
`timescale 1ns/1ps
module mhp_sync #(
  parameter int unsigned W   = 1,
  parameter logic [W-1:0] RV = '0
) (
  input  wire logic         i_ref_clk,
  input  wire logic         i_resetn,
  input  wire logic [W-1:0] i_async,
  output logic      [W-1:0] o_sync
);
  logic [W-1:0] meta;

  // First stage feeds only the second
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      meta   <= RV;
      o_sync <= RV;
    end else begin
      meta   <= i_async;
      o_sync <= meta;
    end
  end
endmodule

// [sim/mhp_host_model.sv]
// Behavioural host driving the parallel and serial pins
`timescale 1ns/1ps
module mhp_host_model (
  input  wire logic       i_ref_clk,
  input  wire logic [7:0] i_bus,
  output logic            o_strap_a,
  output logic            o_strap_b,
  output logic            o_cs_n,
  output logic            o_dc,
  output logic            o_wr,
  output logic            o_rde,
  output logic      [7:0] o_hd
);
  // Idle levels, link clock still
  initial begin
    {o_strap_a, o_strap_b, o_cs_n, o_dc, o_wr, o_rde, o_hd} = 14'h3fff;
  end
  task automatic hold(input int n);
    repeat (n) @(posedge i_ref_clk);
  endtask
  task automatic straps(input logic [1:0] ab);
    o_strap_a <= ab[1];
    o_strap_b <= ab[0];
  endtask
  task automatic pins(input logic cs_n, input logic dc);
    o_cs_n <= cs_n;
    o_dc <= dc;
    o_hd <= 8'hfe;
  endtask
  // 8080 write strobe, or 6800 enable pulse with direction dir
  task automatic par(input logic [7:0] b, input logic dc, input logic cs_n, input logic m68, input logic dir);
    o_cs_n <= cs_n;
    o_dc <= dc;
    o_hd <= b;
    o_wr <= m68 ? dir : 1'b0;
    o_rde <= 1'b1;
    hold(6);
    if (m68) o_rde <= 1'b0;
    else o_wr <= 1'b1;
    hold(6);
    o_cs_n <= 1'b1;
    o_wr <= 1'b1;
    o_hd <= ~b;
    hold(6);
  endtask
  task automatic rd8080(output logic [7:0] d);
    o_cs_n <= 1'b0;
    o_dc <= 1'b1;
    o_hd <= 8'hff;
    o_rde <= 1'b0;
    hold(6);
    d = i_bus;
    o_rde <= 1'b1;
    hold(6);
    o_cs_n <= 1'b1;
  endtask
  // Eight bits MSB first on bit 1, clock on bit 0; optional ninth clock
  task automatic ser(input logic [7:0] b, input logic nine, output logic ack);
    ack = 1'b1;
    for (int i = 7; i >= -1; i--) begin
      hold(3);
      o_hd[1] <= (i >= 0) ? b[i] : 1'b1;
      hold(3);
      if (i >= 0 || nine) o_hd[0] <= 1'b1;
      hold(6);
      if (i < 0) ack = i_bus[1];
      o_hd[0] <= 1'b0;
    end
    hold(6);
  endtask
  task automatic start();
    o_hd[1:0] <= 2'b11;
    hold(6);
    o_hd[1] <= 1'b0;
    hold(6);
    o_hd[0] <= 1'b0;
  endtask
  task automatic stop();
    o_hd[0] <= 1'b1;
    hold(6);
    o_hd[1] <= 1'b1;
    hold(6);
  endtask
endmodule

// [sim/mhp_host_port_properties.sv]
// Assertion checker for the multi-protocol host port
`timescale 1ns/1ps
module mhp_host_port_properties (
  input  wire logic       i_ref_clk,
  input  wire logic       i_resetn,
  input  wire logic       i_protocol_strap_a,
  input  wire logic       i_protocol_strap_b,
  input  wire logic       i_cs_n,
  input  wire logic       i_write_strobe_or_dir,
  input  wire logic       i_read_strobe_or_enable,
  input  wire logic [7:0] i_rd_data,
  input  wire logic [7:0] o_bus,
  input  wire logic [7:0] o_bus_oe_n,
  input  wire logic       o_rx_valid,
  input  wire logic [1:0] o_mode
);
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_resetn);
  // Pin levels held long enough to pass the synchronisers
  sequence s_straps_settled;
    $stable({i_protocol_strap_a, i_protocol_strap_b})[*6];
  endsequence
  sequence s_rd_held;
    (o_mode == 2'b11 && !i_cs_n && !i_read_strobe_or_enable)[*4];
  endsequence
  property p_mode;
    s_straps_settled |-> o_mode == {i_protocol_strap_b, i_protocol_strap_a};
  endproperty
  property p_wr_edge;
    o_rx_valid && o_mode == 2'b11 |-> $past(i_write_strobe_or_dir, 3) && !$past(i_write_strobe_or_dir, 5);
  endproperty
  property p_dir_write;
    o_rx_valid && o_mode == 2'b10 |-> !$past(i_write_strobe_or_dir, 3) && !$past(i_read_strobe_or_enable, 3)
      && $past(i_read_strobe_or_enable, 5);
  endproperty
  property p_rd_drive;
    s_rd_held |-> o_bus_oe_n == 8'h00 && o_bus == $past(i_rd_data);
  endproperty
  property p_rd_release;
    (o_mode == 2'b11 && i_read_strobe_or_enable)[*4] |-> o_bus_oe_n == 8'hff;
  endproperty
  property p_cs_quiet;
    i_cs_n[*5] |-> !o_rx_valid && o_bus_oe_n == 8'hff;
  endproperty
  property p_valid_pulse;
    o_rx_valid |=> !o_rx_valid;
  endproperty
  property p_serial_drive;
    !o_mode[1] |-> o_bus_oe_n == 8'hff || (o_mode == 2'b01 && o_bus_oe_n == 8'hfd && !o_bus[1]);
  endproperty
  a_mode: assert property (p_mode) else $error("mode differs from straps");
  a_wr_edge: assert property (p_wr_edge) else $error("byte without write rising edge");
  a_dir_write: assert property (p_dir_write) else $error("byte without enable fall in write");
  a_rd_drive: assert property (p_rd_drive) else $error("bus not driven in read");
  a_rd_release: assert property (p_rd_release) else $error("bus not released");
  a_cs_quiet: assert property (p_cs_quiet) else $error("activity while deselected");
  a_valid_pulse: assert property (p_valid_pulse) else $error("valid longer than one cycle");
  a_serial_drive: assert property (p_serial_drive) else $error("serial mode drives bus wrongly");
endmodule
bind mhp_host_port mhp_host_port_properties u_props (.i_ref_clk(i_ref_clk), .i_resetn(i_resetn),
  .i_protocol_strap_a(i_protocol_strap_a), .i_protocol_strap_b(i_protocol_strap_b), .i_cs_n(i_cs_n),
  .i_write_strobe_or_dir(i_write_strobe_or_dir), .i_read_strobe_or_enable(i_read_strobe_or_enable),
  .i_rd_data(i_rd_data), .o_bus(o_bus), .o_bus_oe_n(o_bus_oe_n), .o_rx_valid(o_rx_valid), .o_mode(o_mode));

// [sim/multi_protocol_host_port_tb.sv]
// Self-checking bench for the multi-protocol host port
`timescale 1ns/1ps
module multi_protocol_host_port_tb;
  logic       clk, rst_n, sa, sb, cs_n, dc, wr, rde, rx_valid, is_data, ack;
  logic       pwr_n, rd_taken, ctrl_reset;
  logic [7:0] hd, o_bus, oe_n, rd_data, rx_byte, bus_w, d;
  logic [1:0] mode;
  logic [8:0] last;
  int         fail_count = 0, n_compared = 0, got_n = 0, rt_n = 0, n, r;
  // Wire level: device wins where enabled, else the host or pull-up
  assign bus_w = (~oe_n & o_bus) | (oe_n & hd);
  mhp_host_model h (.i_ref_clk(clk), .i_bus(bus_w), .o_strap_a(sa), .o_strap_b(sb), .o_cs_n(cs_n),
    .o_dc(dc), .o_wr(wr), .o_rde(rde), .o_hd(hd));
  mhp_host_port u_dut (.i_ref_clk(clk), .i_resetn(rst_n), .i_protocol_strap_a(sa), .i_protocol_strap_b(sb),
    .i_cs_n(cs_n), .i_power_reset_in_n(pwr_n), .i_data_command_select(dc), .i_write_strobe_or_dir(wr),
    .i_read_strobe_or_enable(rde), .i_bus(bus_w), .o_bus(o_bus), .o_bus_oe_n(oe_n), .i_rd_data(rd_data),
    .o_rd_taken(rd_taken), .o_rx_valid(rx_valid), .o_rx_byte(rx_byte), .o_rx_is_data(is_data), .o_mode(mode),
    .o_ctrl_reset(ctrl_reset));
  // Clock
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // Received byte log
  always @(posedge clk) begin
    if (rx_valid === 1'b1) begin
      got_n <= got_n + 1;
      last <= {is_data, rx_byte};
    end
    if (rd_taken === 1'b1) begin
      rt_n <= rt_n + 1;
    end
  end
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    n_compared++;
    if (g !== e) begin
      fail_count++;
      $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic complete_run();
    if (fail_count == 0 && n_compared > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic t_modes();
    for (int m = 0; m < 4; m++) begin
      h.straps(2'(m));
      h.hold(6);
      chk(16'(mode), {14'h0, 1'(m), 1'(m >> 1)});
    end
  endtask
  task automatic t_par8080();
    n = got_n;
    h.par(8'h5a, 1'b0, 1'b0, 1'b0, 1'b0);
    chk(16'(last), 16'h005a);
    h.par(8'ha5, 1'b1, 1'b0, 1'b0, 1'b0);
    chk(16'(last), 16'h01a5);
    h.par(8'h77, 1'b1, 1'b1, 1'b0, 1'b0);
    chk(16'(got_n - n), 16'h0002);
    r = rt_n;
    rd_data <= 8'hc6;
    h.rd8080(d);
    chk(16'(d), 16'h00c6);
    chk(16'(oe_n), 16'h00ff);
    chk(16'(rt_n - r), 16'h0001);
  endtask
  // Controller reset pin blocks writes and shows on its output
  task automatic t_power();
    n = got_n;
    pwr_n <= 1'b0;
    h.hold(6);
    chk(16'(ctrl_reset), 16'h0001);
    h.par(8'h33, 1'b1, 1'b0, 1'b0, 1'b0);
    chk(16'(got_n - n), 16'h0000);
    pwr_n <= 1'b1;
    h.hold(6);
    chk(16'(ctrl_reset), 16'h0000);
  endtask
  task automatic t_6800();
    h.straps(2'b01);
    h.hold(6);
    h.par(8'h81, 1'b1, 1'b0, 1'b1, 1'b0);
    chk(16'(last), 16'h0181);
    n = got_n;
    r = rt_n;
    h.par(8'h00, 1'b0, 1'b0, 1'b1, 1'b1);
    chk(16'(got_n - n), 16'h0000);
    chk(16'(rt_n - r), 16'h0001);
  endtask
  task automatic t_serial();
    h.straps(2'b00);
    h.hold(6);
    h.pins(1'b0, 1'b0);
    h.ser(8'hc3, 1'b0, ack);
    chk(16'(last), 16'h00c3);
    h.pins(1'b0, 1'b1);
    h.ser(8'h3c, 1'b0, ack);
    chk(16'(last), 16'h013c);
    h.pins(1'b1, 1'b0);
    h.straps(2'b10);
    h.hold(6);
    h.pins(1'b0, 1'b0);
    h.hold(6);
    h.start();
    h.ser({mhp_pkg::I2C_ADDR, 1'b0}, 1'b1, ack);
    chk(16'(ack), 16'h0000);
    h.ser(8'h40, 1'b1, ack);
    h.ser(8'h96, 1'b1, ack);
    h.stop();
    chk(16'(last), 16'h0196);
    h.start();
    h.ser({mhp_pkg::I2C_ADDR ^ 7'h01, 1'b0}, 1'b1, ack);
    chk(16'(ack), 16'h0001);
    h.stop();
    h.pins(1'b1, 1'b0);
  endtask
  // Main sequence
  initial begin
    rst_n = 1'b0;
    pwr_n = 1'b1;
    rd_data = 8'h00;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    h.hold(6);
    t_modes();
    t_par8080();
    t_power();
    t_6800();
    t_serial();
    complete_run();
  end
endmodule
